/* File: common/tape_test_pkg.sv */
// constants shared by the tape read/write test sequencer
package tape_test_pkg;
    localparam int CLK_MHZ = 100;
    // write start-up delay and strobe delay after a character update
    localparam int START_DELAY_MS = 50;
    localparam int START_CYC = START_DELAY_MS * 1000 * CLK_MHZ;
    localparam int STROBE_DLY_NS = 400;
    localparam int STROBE_DLY_CYC = (STROBE_DLY_NS * CLK_MHZ + 999) / 1000;
    // write character period; arbitrary default rate of 10 kHz
    localparam int WR_PERIOD_US = 100;
    localparam int WR_PERIOD_CYC = WR_PERIOD_US * CLK_MHZ;
    // check window widths for ten characters at 800 bpi
    localparam int CW_LO_US = 1000;
    localparam int CW_HI_US = 500;
    localparam int CW_HI45_US = 277;
    localparam int CW_LO_CYC = CW_LO_US * CLK_MHZ;
    localparam int CW_HI_CYC = CW_HI_US * CLK_MHZ;
    localparam int CW_HI45_CYC = CW_HI45_US * CLK_MHZ;
    localparam int DISPLAY_MS = 250;
    localparam int DISPLAY_CYC = DISPLAY_MS * 1000 * CLK_MHZ;
    localparam int CHARS_PER_CYCLE = 10;
    localparam logic [3:0] RESET_ONES = 4'h3;
    localparam logic [3:0] RESET_PULSE_IDX = 4'h6;
    localparam logic [2:0] TAIL_PERIODS = 3'h4;
    localparam int TRACKS = 9;
    localparam int SYNC_W = TRACKS + 2;
    // register map, byte addresses
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int CTRL_BLOCK = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_CYCLE = 2;
    localparam int CTRL_ODD = 3;
    localparam int CTRL_PAT_LSB = 4;
    localparam int CTRL_LEVEL = 6;
    localparam int CTRL_SPEED_LSB = 7;
    localparam int CTRL_WBLOCK = 9;
    localparam int CTRL_W = 10;
    typedef enum logic [1:0] {PAT_FIXED, PAT_ROTATE, PAT_RESET, PAT_SPARE}
        pattern_e;
endpackage : tape_test_pkg

/* File: design/tape_rw_test_sequencer.sv */
// tape unit write pattern generator and read parity checker
//
// Notes on behaviour
// - one character per write strobe pulse
// - hold off strobes after gate start-up delay
// - reset-check: three ones, seven zeros, reset on the seventh character
// - rotating bit advances one track per character
// - fixed pattern all ones or zeros
// - detect vertical and longitudinal parity errors
// - parity sense selects even or odd
// - first vertical error sets sticky flag
// - stop-mode toggle clears vertical flag in continuous mode
// - one pulse per vertical error
// - continuous mode issues no motion commands
// - block mode checker interrupts motion per block
// - error-stop halts motion and holds it
// - check window follows read data interval
// - check window ten characters, speed dependent
// - cycle select resumes motion from halt
// - cycle alternates forward and reverse
// - end-of-data two and half strobes after gate
// - window end: stop, display, then clear, restart unless halted
// - reset pulse four strobes after gate end
// - data stable before delayed write strobe
module tape_rw_test_sequencer
    import tape_test_pkg::*;
#(
    parameter int START_CYCLES = tape_test_pkg::START_CYC,
    parameter int WR_PERIOD_CYCLES = tape_test_pkg::WR_PERIOD_CYC,
    parameter int CW_LO_CYCLES = tape_test_pkg::CW_LO_CYC,
    parameter int CW_HI_CYCLES = tape_test_pkg::CW_HI_CYC,
    parameter int CW_HI45_CYCLES = tape_test_pkg::CW_HI45_CYC,
    parameter int DISPLAY_CYCLES = tape_test_pkg::DISPLAY_CYC
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic write_block_gate,
    input wire logic read_strobe,
    input wire logic [tape_test_pkg::TRACKS-1:0] read_data,
    output logic [tape_test_pkg::TRACKS-1:0] write_data,
    output logic write_strobe,
    output logic write_reset_pulse,
    output logic forward_motion_command,
    output logic reverse_motion_command,
    output logic display_gate,
    output logic vert_error_pulse,
    output logic vertical_error_flag
);
    import tape_test_pkg::*;

    typedef enum {W_IDLE, W_START, W_RUN, W_TAIL} wstate_e;
    typedef enum {R_DATA, R_EOD, R_CHECK, R_DISPLAY} rstate_e;

    logic [CTRL_W-1:0] ctrl_r;
    logic wait_r;
    logic [SYNC_W-1:0] s1_r, s2_r, s3_r, in_r;
    logic gate_q_r, strobe_q_r;
    wstate_e wst_r;
    rstate_e rst_st_r;
    logic [31:0] wcnt_r, wper_r, rcnt_r, rper_r, rgap_r;
    logic [3:0] idx_r;
    logic [2:0] tail_r;
    logic [TRACKS-2:0] rot_r;
    logic [TRACKS-1:0] lacc_r, lerr_r;
    logic halt_r, dir_r;
    logic [31:0] cw_cyc;

    wire block_mode = ctrl_r[CTRL_BLOCK];
    wire stop_mode_select = ctrl_r[CTRL_STOP];
    wire cycle_select = ctrl_r[CTRL_CYCLE];
    wire parity_odd = ctrl_r[CTRL_ODD];
    wire [1:0] pattern_sel = ctrl_r[CTRL_PAT_LSB+1:CTRL_PAT_LSB];
    wire level_select = ctrl_r[CTRL_LEVEL];
    wire [1:0] speed_range_select = ctrl_r[CTRL_SPEED_LSB+1:CTRL_SPEED_LSB];
    wire write_block_mode = ctrl_r[CTRL_WBLOCK];

    wire gate_lvl = in_r[SYNC_W-1];
    wire strobe_lvl = in_r[SYNC_W-2];
    wire [TRACKS-1:0] rd_lvl = in_r[TRACKS-1:0];
    wire gate_rise = gate_lvl && !gate_q_r;
    wire gate_fall = !gate_lvl && gate_q_r;
    wire rd_char = strobe_lvl && !strobe_q_r;
    // the period that ends a block carries no character and no strobe
    wire tail_go = write_block_mode && !gate_lvl && wper_r == 32'h0;
    wire char_tick = wst_r == W_RUN && wper_r == 32'h0 && !tail_go;
    wire bus_take = (avs_read || avs_write) && !wait_r;
    wire ctrl_wr = avs_write && bus_take && avs_address == CTRL_ADDR;
    wire stop_toggle = ctrl_wr && avs_writedata[CTRL_STOP] != stop_mode_select;
    wire vert_bad = rd_char && (^rd_lvl) != parity_odd;
    wire window_end = rst_st_r == R_CHECK && rcnt_r == 32'h0;
    wire display_end = rst_st_r == R_DISPLAY && rcnt_r == 32'h0;
    wire restart = display_end && (!halt_r || cycle_select);

    // one wait state: waitrequest drops for one cycle per request
    always_ff @(posedge mclk)
    begin
        if (rst)
            wait_r <= 1'b1;
        else
            wait_r <= !((avs_read || avs_write) && wait_r);
    end
    assign avs_waitrequest = wait_r;

    always_ff @(posedge mclk)
    begin
        if (rst)
            ctrl_r <= CTRL_W'(CTRL_RESET);
        else if (ctrl_wr)
            ctrl_r <= avs_writedata[CTRL_W-1:0];
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            avs_readdata <= 32'h0;
        else if (avs_read && wait_r)
        begin
            case (avs_address)
                CTRL_ADDR: avs_readdata <= {22'h0, ctrl_r};
                STATUS_ADDR: avs_readdata <= {18'h0, reverse_motion_command,
                    forward_motion_command, display_gate, halt_r, lerr_r,
                    vertical_error_flag};
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

    // three-stage sampling; a level counts once stages two and three agree
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            in_r <= '0;
            gate_q_r <= 1'b0;
            strobe_q_r <= 1'b0;
        end
        else
        begin
            s1_r <= {write_block_gate, read_strobe, read_data};
            s2_r <= s1_r;
            s3_r <= s2_r;
            in_r <= (s2_r & s3_r) | (~(s2_r ^ s3_r) & s2_r) |
                ((s2_r ^ s3_r) & in_r);
            gate_q_r <= gate_lvl;
            strobe_q_r <= strobe_lvl;
        end
    end

    // write sequencer
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wst_r <= W_IDLE;
            wcnt_r <= 32'h0;
            tail_r <= 3'h0;
        end
        else
        begin
            case (wst_r)
                W_IDLE:
                begin
                    // block writes are held off while the display gate stands; continuous writes start regardless
                    if (!write_block_mode)
                        wst_r <= W_RUN;
                    else if (gate_rise && !display_gate)
                    begin
                        wst_r <= W_START;
                        wcnt_r <= 32'(START_CYCLES - 1);
                    end
                end
                W_START:
                begin
                    if (!gate_lvl)
                        wst_r <= W_IDLE;
                    else if (wcnt_r == 32'h0)
                        wst_r <= W_RUN;
                    else
                        wcnt_r <= wcnt_r - 32'h1;
                end
                W_RUN:
                begin
                    if (tail_go)
                    begin
                        wst_r <= W_TAIL;
                        tail_r <= 3'h1;
                    end
                end
                // count four periods after gate end
                W_TAIL:
                begin
                    if (wper_r == 32'h0)
                    begin
                        if (tail_r == TAIL_PERIODS)
                            wst_r <= W_IDLE;
                        else
                            tail_r <= tail_r + 3'h1;
                    end
                end
                default: wst_r <= W_IDLE;
            endcase
        end
    end

    // character period counter, runs in run and tail states
    always_ff @(posedge mclk)
    begin
        if (rst || wst_r == W_IDLE || wst_r == W_START)
            wper_r <= 32'h0;
        else if (wper_r == 32'(WR_PERIOD_CYCLES - 1))
            wper_r <= 32'h0;
        else
            wper_r <= wper_r + 32'h1;
    end

    // character update; the strobe follows STROBE_DLY_CYC later
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            idx_r <= 4'h0;
            rot_r <= '0;
            write_data <= '0;
        end
        else if (char_tick)
        begin
            idx_r <= (idx_r == 4'(CHARS_PER_CYCLE - 1)) ? 4'h0 : idx_r + 4'h1;
            rot_r <= (rot_r == '0) ? (TRACKS-1)'(1) :
                {rot_r[TRACKS-3:0], rot_r[TRACKS-2]};
            case (pattern_e'(pattern_sel))
                PAT_FIXED: write_data[TRACKS-2:0] <= {(TRACKS-1){level_select}};
                PAT_ROTATE: write_data[TRACKS-2:0] <= (rot_r == '0) ?
                    (TRACKS-1)'(1) : {rot_r[TRACKS-3:0], rot_r[TRACKS-2]};
                // three ones then seven zeros on every data track
                PAT_RESET: write_data[TRACKS-2:0] <=
                    {(TRACKS-1){idx_r < RESET_ONES}};
                default: write_data[TRACKS-2:0] <= '0;
            endcase
        end
        else
            write_data[TRACKS-1] <= parity_odd ^ (^write_data[TRACKS-2:0]);
    end

    // strobe delayed from the character update
    always_ff @(posedge mclk)
    begin
        if (rst)
            write_strobe <= 1'b0;
        else
            write_strobe <= wst_r == W_RUN &&
                wper_r == 32'(STROBE_DLY_CYC);
    end

    // reset pulse on the seventh character of the reset-check cycle
    always_ff @(posedge mclk)
    begin
        if (rst)
            write_reset_pulse <= 1'b0;
        else
            write_reset_pulse <= (char_tick && pattern_e'(pattern_sel) ==
                PAT_RESET && idx_r == RESET_PULSE_IDX) ||
                (wst_r == W_TAIL && wper_r == 32'h0 &&
                tail_r == TAIL_PERIODS);
    end

    // read strobe period, used to time end-of-data
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rgap_r <= 32'h0;
            rper_r <= 32'h0;
        end
        else if (rd_char)
        begin
            rper_r <= rgap_r;
            rgap_r <= 32'h0;
        end
        else if (rgap_r != 32'hFFFF_FFFF)
            rgap_r <= rgap_r + 32'h1;
    end

    // ten-character window width by speed range
    always_comb
    begin
        case (speed_range_select)
            2'h0: cw_cyc = 32'(CW_LO_CYCLES);
            2'h1: cw_cyc = 32'(CW_HI_CYCLES);
            default: cw_cyc = 32'(CW_HI45_CYCLES);
        endcase
    end

    // read block sequence
    always_ff @(posedge mclk)
    begin
        if (rst || !block_mode)
        begin
            rst_st_r <= R_DATA;
            rcnt_r <= 32'h0;
        end
        else
        begin
            case (rst_st_r)
                // end-of-data two and a half strobe periods on
                R_DATA:
                begin
                    if (gate_fall)
                    begin
                        rst_st_r <= R_EOD;
                        rcnt_r <= rper_r * 32'h2 + (rper_r >> 1);
                    end
                end
                // window opens as read data ends
                R_EOD:
                begin
                    if (rcnt_r == 32'h0)
                    begin
                        rst_st_r <= R_CHECK;
                        rcnt_r <= cw_cyc;
                    end
                    else
                        rcnt_r <= rcnt_r - 32'h1;
                end
                R_CHECK:
                begin
                    if (window_end)
                    begin
                        rst_st_r <= R_DISPLAY;
                        rcnt_r <= 32'(DISPLAY_CYCLES);
                    end
                    else
                        rcnt_r <= rcnt_r - 32'h1;
                end
                // display, then clear and restart unless halted
                R_DISPLAY:
                begin
                    if (restart)
                        rst_st_r <= R_DATA;
                    else if (rcnt_r != 32'h0)
                        rcnt_r <= rcnt_r - 32'h1;
                end
                default: rst_st_r <= R_DATA;
            endcase
        end
    end

    // per-track xor across block and check character
    // longitudinal errors caught when the window closes
    always_ff @(posedge mclk)
    begin
        if (rst || restart)
        begin
            lacc_r <= '0;
            lerr_r <= '0;
        end
        else
        begin
            // reads outside block mode must not leak into the first block
            if (rst_st_r == R_DISPLAY || !block_mode)
                lacc_r <= '0;
            else if (rd_char)
                lacc_r <= lacc_r ^ rd_lvl;
            if (window_end)
                lerr_r <= lacc_r;
        end
    end

    // parity sense; one pulse per bad character
    always_ff @(posedge mclk)
    begin
        if (rst)
            vert_error_pulse <= 1'b0;
        else
            vert_error_pulse <= vert_bad;
    end

    // sticky flag; a new error wins over any clear
    // stop-mode toggle clears it in continuous mode
    always_ff @(posedge mclk)
    begin
        if (rst)
            vertical_error_flag <= 1'b0;
        else if (vert_error_pulse)
            vertical_error_flag <= 1'b1;
        else if ((stop_toggle && !block_mode) || restart)
            vertical_error_flag <= 1'b0;
    end

    // error-stop halt, held until cycle or mode change
    always_ff @(posedge mclk)
    begin
        if (rst || !block_mode || cycle_select)
            halt_r <= 1'b0;
        else if (stop_mode_select && (vert_error_pulse || lerr_r != '0))
            halt_r <= 1'b1;
    end

    // alternate direction every block in cycle operation
    always_ff @(posedge mclk)
    begin
        if (rst || !cycle_select)
            dir_r <= 1'b0;
        else if (restart)
            dir_r <= !dir_r;
    end

    // no motion command outside block mode
    // block mode stops motion per block
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            forward_motion_command <= 1'b0;
            reverse_motion_command <= 1'b0;
            display_gate <= 1'b0;
        end
        else
        begin
            forward_motion_command <= block_mode && !halt_r &&
                rst_st_r != R_DISPLAY && !dir_r;
            reverse_motion_command <= block_mode && !halt_r &&
                rst_st_r != R_DISPLAY && dir_r;
            display_gate <= block_mode && rst_st_r == R_DISPLAY;
        end
    end

    sequence s_char_update;
        char_tick;
    endsequence

    sequence s_window_close;
        rst_st_r == R_CHECK && rcnt_r == 32'h0;
    endsequence

    a_strobe_after_data: assert property (@(posedge mclk) disable iff (rst)
        s_char_update |-> ##41 write_strobe && $stable(write_data[7:0]))
        else $error("write strobe not delayed after data update");

    a_no_strobe_start: assert property (@(posedge mclk) disable iff (rst)
        wst_r == W_START |=> !write_strobe)
        else $error("write strobe during start-up delay");

    a_strobe_single: assert property (@(posedge mclk) disable iff (rst)
        write_strobe |=> !write_strobe)
        else $error("write strobe longer than one cycle");

    a_vert_pulse_flag: assert property (@(posedge mclk) disable iff (rst)
        vert_error_pulse |=> vertical_error_flag)
        else $error("vertical flag not set after error pulse");

    a_vert_check: assert property (@(posedge mclk) disable iff (rst)
        rd_char && ((^rd_lvl) != parity_odd) |=> vert_error_pulse)
        else $error("vertical parity error not reported");

    a_cont_no_motion: assert property (@(posedge mclk) disable iff (rst)
        !block_mode ##1 !block_mode |-> !forward_motion_command &&
        !reverse_motion_command)
        else $error("motion command in continuous mode");

    a_window_to_display: assert property (@(posedge mclk) disable iff (rst)
        s_window_close ##0 block_mode ##1 block_mode |=> display_gate &&
        !forward_motion_command)
        else $error("display gate not raised at window end");

    a_halt_stops: assert property (@(posedge mclk) disable iff (rst)
        halt_r |=> !forward_motion_command && !reverse_motion_command)
        else $error("motion continues while halted");

    a_reset_check: assert property (@(posedge mclk) disable iff (rst)
        s_char_update ##0 pattern_sel == 2'h2 ##0 idx_r == 4'h6 |=>
        write_reset_pulse)
        else $error("reset pulse missing on seventh character");

    a_long_capture: assert property (@(posedge mclk) disable iff (rst)
        s_window_close ##0 block_mode |=> lerr_r == $past(lacc_r))
        else $error("longitudinal errors not captured");

endmodule : tape_rw_test_sequencer

/* File: tb/tape_unit_model.sv */
// behavioural tape unit: drives read characters on a timed strobe when the bench calls send_char
module tape_unit_model
(
    input wire logic [8:0] write_data,
    input wire logic write_strobe,
    output logic read_strobe,
    output logic [8:0] read_data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        read_strobe = 1'b0;
        read_data = 9'h000;
    end
    // one strobe per character
    // strobe stands still between characters; data stops holding after it
    task automatic send_char(input logic [8:0] d);
        read_data = d;
        #20 read_strobe = 1'b1;
        #40 read_strobe = 1'b0;
        #20 read_data = ~d;
    endtask : send_char
endmodule : tape_unit_model

/* File: tb/tb_tape_rw_test_sequencer.sv */
// self-checking bench for the tape read/write test sequencer
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_tape_rw_test_sequencer;
    import tape_test_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int START = 200;
    logic mclk, rst, avs_read, avs_write, write_block_gate;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic avs_waitrequest, read_strobe, write_strobe, write_reset_pulse;
    logic forward_motion_command, reverse_motion_command, display_gate;
    logic vert_error_pulse, vertical_error_flag;
    logic [8:0] read_data, write_data, d;
    logic [16:0] lfsr = 17'h11EF5;
    logic [7:0] exp_q[$];
    int bad_count = 0, num_checks = 0, ws_cnt = 0, wr_cnt = 0, ve_cnt = 0;
    int mot_cnt = 0, ones, base, exp_err;
    tape_rw_test_sequencer #(.START_CYCLES(START), .WR_PERIOD_CYCLES(100),
        .CW_LO_CYCLES(1000), .CW_HI_CYCLES(500), .CW_HI45_CYCLES(300),
        .DISPLAY_CYCLES(200)) dut_u (.mclk(mclk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .write_block_gate(write_block_gate), .read_strobe(read_strobe),
        .read_data(read_data), .write_data(write_data),
        .write_strobe(write_strobe), .write_reset_pulse(write_reset_pulse),
        .forward_motion_command(forward_motion_command),
        .reverse_motion_command(reverse_motion_command),
        .display_gate(display_gate), .vert_error_pulse(vert_error_pulse),
        .vertical_error_flag(vertical_error_flag));
    tape_unit_model tape_u (.write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe),
        .read_data(read_data));
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    function automatic logic [16:0] lfsr_next(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr_next
    // the watcher takes the oldest note at each strobe
    always @(posedge mclk)
    begin
        if (write_strobe === 1'b1 && exp_q.size() > 0)
            `CHK(write_data[7:0], exp_q.pop_front())
        if (write_strobe === 1'b1)
            ws_cnt++;
        if (write_reset_pulse === 1'b1)
            wr_cnt++;
        if (vert_error_pulse === 1'b1)
            ve_cnt++;
        if (forward_motion_command === 1'b1 || reverse_motion_command === 1'b1)
            mot_cnt++;
    end
    task automatic av_xfer(input logic wr, input logic [3:0] a,
        input logic [31:0] wd, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        // waitrequest is sampled at each rising edge; the low one takes
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
            bad_count++;
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : av_xfer
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    task automatic wait_strobes(input int n);
        repeat (n) @(posedge mclk iff write_strobe === 1'b1);
    endtask : wait_strobes
    task automatic send_chars(input logic odd);
        exp_err = 0;
        base = ve_cnt;
        for (int i = 0; i < 8; i++)
        begin
            lfsr = lfsr_next(lfsr);
            d = (i == 0) ? {8'h00, ~odd} : lfsr[8:0];
            exp_err += int'((^d) ^ odd);
            tape_u.send_char(d);
        end
        repeat (20) @(posedge mclk);
        `CHK(ve_cnt - base, exp_err)
        `CHK(vertical_error_flag, 1'b1)
    endtask : send_chars
    initial
    begin
        #200us;
        bad_count++;
        results();
    end
    initial
    begin
        rst = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        write_block_gate = 1'b0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        av_xfer(1'b0, CTRL_ADDR, 32'h0, rd);
        `CHK(rd, CTRL_RESET)
        av_xfer(1'b0, 4'h8, 32'h0, rd);
        `CHK(rd, 32'h0000_0000)
        // fixed level one then zero, continuous write
        for (int lv = 1; lv >= 0; lv--)
        begin
            av_xfer(1'b1, CTRL_ADDR, 32'(lv) << CTRL_LEVEL, rd);
            wait_strobes(2);
            repeat (3) exp_q.push_back(lv ? 8'hFF : 8'h00);
            wait_strobes(4);
        end
        av_xfer(1'b0, CTRL_ADDR, 32'h0, rd);
        `CHK(rd, 32'h0000_0000)
        av_xfer(1'b1, CTRL_ADDR, 32'h0000_0020, rd);
        wait_strobes(2);
        ones = 0;
        base = wr_cnt;
        for (int i = 0; i < 20; i++)
        begin
            wait_strobes(1);
            ones += int'(write_data[7:0] === 8'hFF);
        end
        `CHK(ones, 6)
        `CHK(wr_cnt - base, 2)
        // read side, even then odd sense, continuous mode
        av_xfer(1'b1, CTRL_ADDR, 32'h0, rd);
        send_chars(1'b0);
        av_xfer(1'b1, CTRL_ADDR, 32'h0000_0002, rd);
        repeat (3) @(posedge mclk);
        `CHK(vertical_error_flag, 1'b0)
        av_xfer(1'b1, CTRL_ADDR, 32'h0000_000A, rd);
        send_chars(1'b1);
        `CHK(mot_cnt, 0)
        // block write: gate outlasts the start-up hold-off
        av_xfer(1'b1, CTRL_ADDR, 32'h0000_0240, rd);
        // let the running continuous write finish its tail first
        repeat (600) @(posedge mclk);
        base = ws_cnt;
        ones = wr_cnt;
        write_block_gate <= 1'b1;
        repeat (START - 10) @(posedge mclk);
        `CHK(ws_cnt - base, 0)
        repeat (960) @(posedge mclk);
        write_block_gate <= 1'b0;
        repeat (600) @(posedge mclk);
        `CHK(ws_cnt - base, 10)
        `CHK(wr_cnt - ones, 1)
        // block read: two even characters leave tracks 1 and 2 odd
        av_xfer(1'b1, CTRL_ADDR, 32'h0000_0201, rd);
        repeat (5) @(posedge mclk);
        `CHK(forward_motion_command, 1'b1)
        write_block_gate <= 1'b1;
        @(posedge mclk);
        // the model tape gives no spurious first-block errors
        tape_u.send_char(9'h003);
        tape_u.send_char(9'h005);
        @(posedge mclk);
        write_block_gate <= 1'b0;
        repeat (1100) @(posedge mclk);
        `CHK(display_gate, 1'b1)
        `CHK(forward_motion_command, 1'b0)
        av_xfer(1'b0, STATUS_ADDR, 32'h0, rd);
        `CHK(rd, 32'h0000_080C)
        repeat (200) @(posedge mclk);
        `CHK(forward_motion_command, 1'b1)
        `CHK(display_gate, 1'b0)
        results();
    end
endmodule : tb_tape_rw_test_sequencer
